// *** hdl/mfb_pkg.sv ***
/*
  Constants and types for the MAC build-option block.
  Assumes one 40 MHz clock with synchronous active-high reset.
*/
package mfb_pkg;

  localparam logic [7:0] MFB_PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] MFB_SFD_BYTE      = 8'hd5;
  localparam logic [31:0] MFB_CRC_POLY     = 32'h04c11db7;
  localparam logic [31:0] MFB_CRC_INIT     = 32'hffffffff;
  localparam int unsigned MFB_PRE_LEN      = 8;
  localparam int unsigned MFB_FCS_LEN      = 4;
  localparam int unsigned MFB_CNT_W        = 32;

  // register map
  localparam logic [3:0] MFB_REG_CTRL     = 4'h0;
  localparam logic [3:0] MFB_REG_STATUS   = 4'h1;
  localparam logic [3:0] MFB_REG_MASK     = 4'h2;
  localparam logic [3:0] MFB_REG_TX_FRM   = 4'h3;
  localparam logic [3:0] MFB_REG_RX_FRM   = 4'h4;
  localparam logic [3:0] MFB_REG_RX_BAD   = 4'h5;
  localparam logic [3:0] MFB_REG_BUILD    = 4'h6;
  localparam int unsigned MFB_CTRL_STRICT = 0;
  localparam logic [31:0] MFB_CTRL_RST    = 32'h0;
  localparam logic [2:0]  MFB_MASK_RST    = 3'h0;

  // event bits, shared by status and mask
  localparam int unsigned MFB_EV_TX_DONE = 0;
  localparam int unsigned MFB_EV_RX_DONE = 1;
  localparam int unsigned MFB_EV_RX_ERR  = 2;
  localparam int unsigned MFB_EV_W       = 3;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       sop;
    logic       eop;
  } mfb_byte_t;

  typedef struct packed {
    logic frame_ok;
    logic frame_bad;
    logic [15:0] octets;
  } mfb_inc_t;

endpackage

// *** hdl/mfb_crc.sv ***
/*
  Byte-serial CRC-32 accumulator, reflected Ethernet form.
  Assumes one byte per cycle at most; restart on the frame's first byte.
*/
`timescale 1ns/10ps
module mfb_crc (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc_q,
  output logic      [31:0] fcs
);
  function automatic logic [31:0] step(input logic [31:0] c,
                                       input logic [7:0]  d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ 32'hedb88320;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  always_ff @(posedge clock) begin
    if (reset) begin
      crc_q <= mfb_pkg::MFB_CRC_INIT;
    end else if (en) begin
      crc_q <= step(start ? mfb_pkg::MFB_CRC_INIT : crc_q, data);
    end
  end

  // transmitted least significant byte first
  assign fcs = ~crc_q;
endmodule

// *** hdl/mfb_delay.sv ***
/*
  Fixed pipeline delay for the receive byte stream.
  Assumes DEPTH of at least one.
*/
`timescale 1ns/10ps
module mfb_delay #(
  parameter int unsigned DEPTH = 1
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire mfb_pkg::mfb_byte_t in_b,
  output mfb_pkg::mfb_byte_t      out_b
);
  mfb_pkg::mfb_byte_t pipe_q [DEPTH];

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        pipe_q[i] <= '0;
      end
    end else begin
      pipe_q[0] <= in_b;
      for (int i = 1; i < DEPTH; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  assign out_b = pipe_q[DEPTH-1];
endmodule

// *** hdl/mfb_mac.sv ***
/*
  Byte-wide MAC datapath whose build options are module parameters:
  FCS insertion, preamble pass-through, end-of-packet alignment of the
  FCS error, statistics counters and strict delimiter check.
  Assumes client transmit data has no gaps inside a frame, and line
  receive bytes begin with the preamble and delimiter.
*/
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
module mfb_mac #(
  parameter bit TX_CRC_INSERT = 1'b1,
  parameter bit FLOW_CONTROL  = 1'b0,
  parameter bit PREAMBLE_PASS = 1'b0,
  parameter bit EOP_ALIGN     = 1'b1,
  parameter bit TX_STATS      = 1'b1,
  parameter bit RX_STATS      = 1'b1,
  parameter bit STRICT_SFD    = 1'b0
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [31:0]        reg_rdata,
  output logic                    irq,
  input  wire mfb_pkg::mfb_byte_t tx_in,
  output logic                    tx_ready,
  output mfb_pkg::mfb_byte_t      tx_line,
  input  wire mfb_pkg::mfb_byte_t rx_line,
  output mfb_pkg::mfb_byte_t      rx_out,
  output logic                    rx_fcs_error,
  output mfb_pkg::mfb_inc_t       tx_increment,
  output mfb_pkg::mfb_inc_t       rx_increment
);
  // refuse the illegal build at elaboration
  if (FLOW_CONTROL && !TX_CRC_INSERT) begin : g_bad_build
    $error("flow control build needs fcs insertion");
  end

  // transmit side
  typedef enum {TX_IDLE, TX_PRE, TX_DATA, TX_FCS} mfb_tx_st_t;
  mfb_tx_st_t  tx_st_q;
  logic [2:0]  tx_cnt_q;
  logic [15:0] tx_len_q;
  logic [31:0] tx_fcs;
  logic        tx_take;
  logic        tx_crc_en;
  logic        tx_sop_q;
  logic [7:0]  tx_hold_q;
  logic        tx_held_q;
  logic        tx_pay;

  // pass-through: client byte stream already carries preamble
  // ready drops while the held sop byte goes out, else a byte is lost
  assign tx_ready = (tx_st_q == TX_IDLE) ||
                    (tx_st_q == TX_DATA && !tx_held_q);
  assign tx_take  = tx_in.valid && tx_ready;
  // client preamble bytes stay out of the crc
  assign tx_pay   = !PREAMBLE_PASS ||
                    tx_cnt_q == 3'(mfb_pkg::MFB_PRE_LEN - 1);
  assign tx_crc_en = (tx_st_q == TX_DATA) && (tx_held_q || tx_take) &&
                     tx_pay;

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_st_q  <= TX_IDLE;
      tx_cnt_q <= 3'h0;
      tx_sop_q <= 1'b0;
    end else begin
      unique case (tx_st_q)
        TX_IDLE: begin
          if (tx_take && tx_in.sop) begin
            tx_sop_q <= 1'b1;
            tx_st_q  <= PREAMBLE_PASS ? TX_DATA : TX_PRE;
            tx_cnt_q <= 3'h0;
          end
        end
        TX_PRE: begin
          tx_cnt_q <= tx_cnt_q + 3'h1;
          if (tx_cnt_q == 3'(mfb_pkg::MFB_PRE_LEN - 1)) begin
            tx_st_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_crc_en) begin
            tx_sop_q <= 1'b0;
          end
          if (tx_take && !tx_pay) begin
            tx_cnt_q <= tx_cnt_q + 3'h1;
          end
          if (tx_take && tx_in.eop) begin
            tx_cnt_q <= 3'h0;
            tx_st_q  <= TX_CRC_INSERT ? TX_FCS : TX_IDLE;
          end
        end
        TX_FCS: begin
          tx_cnt_q <= tx_cnt_q + 3'h1;
          if (tx_cnt_q == 3'(mfb_pkg::MFB_FCS_LEN - 1)) begin
            tx_st_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // idle-state sop byte held while the eight preamble bytes go out

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_line   <= '0;
      tx_hold_q <= 8'h0;
      tx_held_q <= 1'b0;
    end else begin
      tx_line <= '0;
      if (tx_st_q == TX_IDLE && tx_take && tx_in.sop && !PREAMBLE_PASS) begin
        tx_hold_q <= tx_in.data;
        tx_held_q <= 1'b1;
      end
      unique case (tx_st_q)
        TX_IDLE: begin
          if (tx_take && tx_in.sop && PREAMBLE_PASS) begin
            tx_line <= '{valid: 1'b1, data: tx_in.data, sop: 1'b1,
                         eop: 1'b0};
          end
        end
        TX_PRE: begin
          tx_line.valid <= 1'b1;
          tx_line.sop   <= (tx_cnt_q == 3'h0);
          tx_line.data  <= (tx_cnt_q == 3'(mfb_pkg::MFB_PRE_LEN - 1)) ?
                           mfb_pkg::MFB_SFD_BYTE : mfb_pkg::MFB_PREAMBLE_BYTE;
        end
        TX_DATA: begin
          if (tx_held_q) begin
            tx_line   <= '{valid: 1'b1, data: tx_hold_q, sop: 1'b0,
                           eop: 1'b0};
            tx_held_q <= 1'b0;
          end else if (tx_take) begin
            tx_line <= '{valid: 1'b1, data: tx_in.data, sop: 1'b0,
                         eop: tx_in.eop && !TX_CRC_INSERT};
          end
        end
        TX_FCS: begin
          tx_line.valid <= 1'b1;
          tx_line.data  <= tx_fcs[8*tx_cnt_q[1:0] +: 8];
          tx_line.eop   <= (tx_cnt_q == 3'(mfb_pkg::MFB_FCS_LEN - 1));
        end
      endcase
    end
  end

  // crc covers the client payload, first byte restarts it
  mfb_crc u_tx_crc (
    .clock (clock),
    .reset (reset),
    .start (tx_sop_q),
    .en    (tx_crc_en),
    .data  (tx_held_q ? tx_hold_q : tx_in.data),
    .crc_q (),
    .fcs   (tx_fcs)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_len_q     <= 16'h0;
      tx_increment <= '0;
    end else begin
      tx_increment <= '0;
      if (tx_take && tx_st_q == TX_DATA && tx_in.eop) begin
        tx_len_q              <= 16'h0;
        tx_increment.frame_ok <= 1'b1;
        tx_increment.octets   <= tx_len_q + 16'h1;
      end else if (tx_crc_en) begin
        tx_len_q <= tx_len_q + 16'h1;
      end
    end
  end

  // receive side
  logic             strict_en_q;
  logic             strict_on;
  logic [3:0]       rx_pos_q;
  logic             rx_in_frame_q;
  logic             rx_drop_q;
  logic [31:0]      rx_crc;
  logic [15:0]      rx_len_q;
  mfb_pkg::mfb_byte_t rx_data_q;
  mfb_pkg::mfb_byte_t rx_delayed;
  logic             rx_body;
  logic             rx_sfd_bad;
  logic             rx_err_now;
  logic             rx_err_late_q;

  assign strict_on  = STRICT_SFD && strict_en_q;
  assign rx_body    = rx_line.valid && rx_in_frame_q &&
                      rx_pos_q == 4'(mfb_pkg::MFB_PRE_LEN);
  assign rx_sfd_bad = rx_line.valid &&
                      rx_pos_q == 4'(mfb_pkg::MFB_PRE_LEN - 1) &&
                      rx_line.data != mfb_pkg::MFB_SFD_BYTE;

  always_ff @(posedge clock) begin
    if (reset) begin
      rx_pos_q      <= 4'h0;
      rx_in_frame_q <= 1'b0;
      rx_drop_q     <= 1'b0;
    end else if (rx_line.valid) begin
      if (rx_line.sop) begin
        rx_pos_q      <= 4'h1;
        rx_in_frame_q <= 1'b1;
        rx_drop_q     <= 1'b0;
      end else if (rx_pos_q != 4'(mfb_pkg::MFB_PRE_LEN)) begin
        rx_pos_q <= rx_pos_q + 4'h1;
        if (rx_sfd_bad && strict_on) begin
          rx_drop_q <= 1'b1;
        end
      end
      if (rx_line.eop) begin
        rx_in_frame_q <= 1'b0;
        rx_pos_q      <= 4'h0;
      end
    end
  end

  mfb_crc u_rx_crc (
    .clock (clock),
    .reset (reset),
    .start (rx_len_q == 16'h0),
    .en    (rx_body),
    .data  (rx_line.data),
    .crc_q (rx_crc),
    .fcs   ()
  );

  // residue check: crc over payload and fcs ends in the magic value
  assign rx_err_now = rx_crc != 32'hdebb20e3;

  // framed receive stream, preamble kept or stripped
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_data_q <= '0;
      rx_len_q  <= 16'h0;
    end else begin
      rx_data_q <= '0;
      if (rx_line.valid && rx_in_frame_q && !rx_drop_q &&
          !(rx_sfd_bad && strict_on)
          || rx_line.valid && rx_line.sop) begin
        if (PREAMBLE_PASS || rx_body) begin
          rx_data_q       <= rx_line;
          rx_data_q.sop   <= PREAMBLE_PASS ? rx_line.sop
                                           : (rx_len_q == 16'h0);
        end
      end
      if (rx_body) begin
        rx_len_q <= rx_line.eop ? 16'h0 : rx_len_q + 16'h1;
      end
    end
  end

  // crc register settles one cycle after the last byte
  mfb_delay #(.DEPTH(1)) u_rx_align (
    .clock (clock),
    .reset (reset),
    .in_b  (rx_data_q),
    .out_b (rx_delayed)
  );

  logic        rx_eop_q;
  logic [15:0] rx_delayed_len_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_eop_q      <= 1'b0;
      rx_err_late_q <= 1'b0;
    end else begin
      rx_eop_q      <= rx_data_q.valid && rx_data_q.eop && !rx_drop_q;
      rx_err_late_q <= rx_eop_q && rx_err_now;
    end
  end

  assign rx_out       = EOP_ALIGN ? rx_delayed : rx_data_q;
  assign rx_fcs_error = EOP_ALIGN ? (rx_eop_q && rx_err_now)
                                  : rx_err_late_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      rx_increment <= '0;
    end else begin
      rx_increment <= '0;
      if (rx_eop_q) begin
        rx_increment.frame_ok  <= !rx_err_now;
        rx_increment.frame_bad <= rx_err_now;
        rx_increment.octets    <= rx_err_now ? 16'h0 : rx_delayed_len_q;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rx_delayed_len_q <= 16'h0;
    end else if (rx_body && rx_line.eop) begin
      rx_delayed_len_q <= rx_len_q + 16'h1;
    end
  end

  // counters, status and registers
  logic [31:0]        tx_frames_q;
  logic [31:0]        rx_frames_q;
  logic [31:0]        rx_bad_q;
  logic [2:0]         status_q;
  logic [2:0]         mask_q;
  logic [2:0]         events;

  if (TX_STATS) begin : g_tx_cnt
    always_ff @(posedge clock) begin
      if (reset) begin
        tx_frames_q <= 32'h0;
      end else if (tx_increment.frame_ok) begin
        tx_frames_q <= tx_frames_q + 32'h1;
      end
    end
  end else begin : g_no_tx_cnt
    assign tx_frames_q = 32'h0;
  end

  if (RX_STATS) begin : g_rx_cnt
    always_ff @(posedge clock) begin
      if (reset) begin
        rx_frames_q <= 32'h0;
        rx_bad_q    <= 32'h0;
      end else begin
        rx_frames_q <= rx_frames_q + {31'h0, rx_increment.frame_ok};
        rx_bad_q    <= rx_bad_q + {31'h0, rx_increment.frame_bad};
      end
    end
  end else begin : g_no_rx_cnt
    assign rx_frames_q = 32'h0;
    assign rx_bad_q    = 32'h0;
  end

  assign events = {rx_fcs_error, rx_increment.frame_ok || rx_fcs_error,
                   tx_increment.frame_ok};

  always_ff @(posedge clock) begin
    if (reset) begin
      strict_en_q <= 1'b0;
      mask_q      <= mfb_pkg::MFB_MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == mfb_pkg::MFB_REG_CTRL) begin
        strict_en_q <= reg_wdata[mfb_pkg::MFB_CTRL_STRICT];
      end
      if (reg_addr == mfb_pkg::MFB_REG_MASK) begin
        mask_q <= reg_wdata[2:0];
      end
    end
  end

  // set wins over the clear on read
  always_ff @(posedge clock) begin
    if (reset) begin
      status_q <= 3'h0;
    end else begin
      status_q <= ((reg_rd && reg_addr == mfb_pkg::MFB_REG_STATUS) ?
                   3'h0 : status_q) | events;
    end
  end

  assign irq = |(status_q & mask_q);

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        unique case (reg_addr)
          mfb_pkg::MFB_REG_CTRL:   reg_rdata <= {31'h0, strict_en_q};
          mfb_pkg::MFB_REG_STATUS: reg_rdata <= {29'h0, status_q};
          mfb_pkg::MFB_REG_MASK:   reg_rdata <= {29'h0, mask_q};
          mfb_pkg::MFB_REG_TX_FRM: reg_rdata <= tx_frames_q;
          mfb_pkg::MFB_REG_RX_FRM: reg_rdata <= rx_frames_q;
          mfb_pkg::MFB_REG_RX_BAD: reg_rdata <= rx_bad_q;
          mfb_pkg::MFB_REG_BUILD:  reg_rdata <= {25'h0, STRICT_SFD, RX_STATS,
                                     TX_STATS, EOP_ALIGN, PREAMBLE_PASS,
                                     FLOW_CONTROL, TX_CRC_INSERT};
          default:                 reg_rdata <= 32'h0;
        endcase
      end
    end
  end

  // checks
  fcs_len_a: assert property (@(posedge clock) disable iff (reset)
    (tx_st_q == TX_DATA && tx_take && tx_in.eop && TX_CRC_INSERT) |->
      ##2 tx_line.valid [*4] ##0 tx_line.eop)
    else $error("fcs not four bytes ending in eop");
  no_fcs_a: assert property (@(posedge clock) disable iff (reset)
    (tx_take && tx_st_q == TX_DATA && tx_in.eop && !TX_CRC_INSERT) |->
      ##1 tx_line.eop)
    else $error("eop not passed through");
  align_err_a: assert property (@(posedge clock) disable iff (reset)
    (EOP_ALIGN && rx_fcs_error) |-> rx_out.eop)
    else $error("fcs error not on eop");
  late_err_a: assert property (@(posedge clock) disable iff (reset)
    (!EOP_ALIGN && rx_fcs_error) |-> !rx_out.valid || !rx_out.eop)
    else $error("late fcs error on eop");
  strict_off_a: assert property (@(posedge clock) disable iff (reset)
    !STRICT_SFD |-> !rx_drop_q)
    else $error("drop without strict build");
  tx_inc_a: assert property (@(posedge clock) disable iff (reset)
    (tx_take && tx_st_q == TX_DATA && tx_in.eop) |=> tx_increment.frame_ok)
    else $error("tx increment missing");
  rx_inc_a: assert property (@(posedge clock) disable iff (reset)
    rx_eop_q |=> (rx_increment.frame_ok ^ rx_increment.frame_bad))
    else $error("rx increment missing");
  irq_level_a: assert property (@(posedge clock) disable iff (reset)
    $rose(status_q[0]) && mask_q[0] |-> irq)
    else $error("irq not raised");
endmodule

// *** tb/mfb_client.sv ***
/*
  Client model on the MAC transmit stream: sends one frame per go pulse.
  Assumes go is pulsed only while busy is low; data byte k is 8'h10 + k.
*/
`timescale 1ns/10ps
module mfb_client (
  input  wire logic          clock,
  input  wire logic          reset,
  input  wire logic          ready,
  input  wire logic          go,
  input  wire logic          with_pre,
  input  wire logic [7:0]    len,
  output mfb_pkg::mfb_byte_t tx_in,
  output logic               busy
);
  logic [7:0] idx_q;
  logic [7:0] total;

  // pass-through builds get the preamble from us
  assign total = len + (with_pre ? 8'h08 : 8'h00);

  function automatic logic [7:0] byte_at(input logic [7:0] i,
                                         input logic       wp);
    if (wp && i < 8'h07) return 8'h55;
    if (wp && i == 8'h07) return 8'hd5;
    return 8'h10 + i - (wp ? 8'h08 : 8'h00);
  endfunction

  always_ff @(posedge clock) begin
    if (reset) begin
      busy  <= 1'b0;
      idx_q <= 8'h00;
      tx_in <= '0;
    end else if (!busy) begin
      // idle data toggles so a stale byte is never mistaken for fresh
      tx_in.valid <= go;
      tx_in.sop   <= go;
      tx_in.eop   <= go && total == 8'h01;
      tx_in.data  <= go ? byte_at(8'h00, with_pre) : ~tx_in.data;
      busy        <= go;
      idx_q       <= 8'h00;
    end else if (ready) begin
      // no gaps inside a frame
      tx_in.valid <= !tx_in.eop;
      tx_in.sop   <= 1'b0;
      tx_in.eop   <= idx_q + 8'h02 == total;
      tx_in.data  <= tx_in.eop ? ~tx_in.data
                               : byte_at(idx_q + 8'h01, with_pre);
      busy        <= !tx_in.eop;
      idx_q       <= idx_q + 8'h01;
    end
  end
endmodule

// *** tb/mfb_mac_bench.sv ***
/*
  Self-checking bench: two builds of the MAC side by side.
  Assumes the register map, byte timing and latencies of the design notes.
*/
`timescale 1ns/10ps
module mfb_mac_bench;
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic [3:0]         reg_addr = 4'h0;
  logic [31:0]        reg_wdata = 32'h0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  mfb_pkg::mfb_byte_t rx_line = '0;
  logic [1:0]         go = 2'b00;
  logic [7:0]         len = 8'h06;
  wire  [1:0]         irq, ready, busy, err;
  wire  [31:0]        rdata [2];
  wire mfb_pkg::mfb_byte_t tx_in [2], tx_line [2], rx_out [2];
  wire mfb_pkg::mfb_inc_t  tx_inc [2], rx_inc [2];
  int                 failures = 0;
  int                 n_checks = 0;
  int                 cyc = 0;
  int                 ls_at = 0;
  int                 tn [2], rn [2], first_out [2], eop_at [2], err_at [2];
  int                 tx_ok [2], rx_ok [2], rx_bad [2];
  int                 tx_oct [2], rx_oct [2];
  logic [7:0]         tbuf [2][32];
  logic [7:0]         rbuf [2][32];
  logic [31:0]        rd_v [2];

  always #12.5 clock = ~clock;

  // build 1 has no alignment, so its receive octet increments go unused
  // flow control stays off where insertion is left out
  for (genvar k = 0; k < 2; k++) begin : g
    mfb_mac #(
      .TX_CRC_INSERT(k == 0), .PREAMBLE_PASS(k == 1), .EOP_ALIGN(k == 0),
      .TX_STATS(k == 0), .RX_STATS(k == 0), .STRICT_SFD(k == 0)
    ) dut_u (
      .clock(clock), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(rdata[k]), .irq(irq[k]), .tx_in(tx_in[k]),
      .tx_ready(ready[k]), .tx_line(tx_line[k]), .rx_line(rx_line),
      .rx_out(rx_out[k]), .rx_fcs_error(err[k]),
      .tx_increment(tx_inc[k]), .rx_increment(rx_inc[k])
    );
    mfb_client cli_u (
      .clock(clock), .reset(reset), .ready(ready[k]), .go(go[k]),
      .with_pre(k == 1), .len(len), .tx_in(tx_in[k]), .busy(busy[k])
    );
  end

  always @(posedge clock) begin
    cyc = cyc + 1;
    if (rx_line.valid && rx_line.sop) ls_at = cyc;
    for (int k = 0; k < 2; k++) begin
      if (tx_line[k].valid) begin
        if (tn[k] < 32) tbuf[k][tn[k]] = tx_line[k].data;
        tn[k]++;
      end
      if (rx_out[k].valid) begin
        if (rn[k] == 0) first_out[k] = cyc;
        if (rn[k] < 32) rbuf[k][rn[k]] = rx_out[k].data;
        rn[k]++;
        if (rx_out[k].eop) eop_at[k] = cyc;
      end
      if (err[k] && err_at[k] < 0) err_at[k] = cyc;
      tx_ok[k] += tx_inc[k].frame_ok;
      rx_ok[k] += rx_inc[k].frame_ok;
      rx_bad[k] += rx_inc[k].frame_bad;
      if (tx_inc[k].frame_ok) tx_oct[k] = tx_inc[k].octets;
      if (rx_inc[k].frame_ok || rx_inc[k].frame_bad)
        rx_oct[k] = rx_inc[k].octets;
    end
  end

  task automatic clr();
    for (int k = 0; k < 2; k++) begin
      tn[k] = 0;
      rn[k] = 0;
      first_out[k] = -1;
      err_at[k] = -1;
      eop_at[k] = -1;
      tx_ok[k] = 0;
      rx_ok[k] = 0;
      rx_bad[k] = 0;
      tx_oct[k] = -1;
      rx_oct[k] = -1;
    end
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] dbyte(input int i);
    return 8'h10 + 8'(i);
  endfunction

  function automatic logic [31:0] crc32(input int n);
    logic [31:0] c;
    c = mfb_pkg::MFB_CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h0, dbyte(i)};
      // bit-reversed generator, since bits go out lsb first
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    rd_v[0] = rdata[0];
    rd_v[1] = rdata[1];
  endtask

  task automatic wait_idle();
    int i;
    // busy rises only at the edge where go is seen
    @(posedge clock);
    for (i = 0; i < 300 && busy != 2'b00; i++) @(posedge clock);
    if (i == 300) begin
      failures++;
      close_out();
    end
    repeat (12) @(posedge clock);
  endtask

  task automatic send_rx(input int n, input logic bad, input logic [7:0] sfd);
    logic [31:0] c;
    logic [7:0]  b;
    c = crc32(n);
    for (int i = 0; i < n + 12; i++) begin
      if (i < 7) b = 8'h55;
      else if (i == 7) b = sfd;
      else if (i < n + 8) b = dbyte(i - 8);
      else b = c[8 * (i - n - 8) +: 8] ^ {7'h0, bad};
      rx_line <= '{1'b1, b, i == 0, i == n + 11};
      @(posedge clock);
    end
    rx_line <= '{1'b0, ~b, 1'b0, 1'b0};
    repeat (12) @(posedge clock);
  endtask

  task automatic t_regs();
    wr(4'hf, 32'hffffffff);
    // ctrl, status, mask, then the unmapped slot
    for (int i = 0; i < 4; i++) begin
      rd(i == 3 ? 4'hf : 4'(i));
      chk("reset value", rd_v[0], 32'h0);
    end
    rd(mfb_pkg::MFB_REG_BUILD);
    chk("build0", rd_v[0], 32'h79);
    chk("build1", rd_v[1], 32'h04);
  endtask

  task automatic t_tx();
    logic [31:0] c;
    logic [7:0]  b;
    c = crc32(6);
    clr();
    go <= 2'b11;
    @(posedge clock);
    go <= 2'b00;
    wait_idle();
    chk("tx0 length", tn[0], 18);
    chk("tx1 length", tn[1], 14);
    for (int i = 0; i < 14; i++) begin
      b = i < 7 ? 8'h55 : i == 7 ? 8'hd5 : dbyte(i - 8);
      chk("tx0 byte", tbuf[0][i], b);
      chk("tx1 byte", tbuf[1][i], b);
    end
    for (int j = 0; j < 4; j++) chk("tx0 fcs", tbuf[0][14 + j], c[8*j +: 8]);
    chk("tx0 inc", tx_ok[0], 1);
    chk("tx1 inc", tx_ok[1], 1);
    chk("tx0 octets", tx_oct[0], 6);
    chk("tx1 octets", tx_oct[1], 6);
    rd(mfb_pkg::MFB_REG_TX_FRM);
    chk("tx0 count", rd_v[0], 1);
    chk("tx1 count", rd_v[1], 0);
  endtask

  task automatic t_irq();
    chk("irq masked", irq[0], 0);
    wr(mfb_pkg::MFB_REG_MASK, 32'h1);
    @(posedge clock);
    chk("irq raised", irq[0], 1);
    rd(mfb_pkg::MFB_REG_STATUS);
    chk("status", rd_v[0], 32'h1);
    chk("irq cleared", irq[0], 0);
  endtask

  task automatic t_rx(input logic bad);
    clr();
    send_rx(5, bad, 8'hd5);
    chk("rx0 latency", first_out[0] - ls_at, 10);
    chk("rx1 latency", first_out[1] - ls_at, 1);
    for (int i = 0; i < 8; i++) chk("rx1 pre", rbuf[1][i], i < 7 ? 8'h55 : 8'hd5);
    for (int i = 0; i < 5; i++) begin
      chk("rx0 data", rbuf[0][i], dbyte(i));
      chk("rx1 data", rbuf[1][i + 8], dbyte(i));
    end
    chk("rx0 err", err_at[0] == eop_at[0], bad);
    chk("rx1 err", err_at[1] > eop_at[1] && err_at[1] <= eop_at[1] + 8, bad);
    chk("rx0 ok", rx_ok[0], !bad);
    chk("rx1 ok", rx_ok[1], !bad);
    chk("rx1 bad", rx_bad[1], bad);
    chk("rx0 bad", rx_bad[0], bad);
    chk("rx0 octets", rx_oct[0], bad ? 0 : 5 + mfb_pkg::MFB_FCS_LEN);
    rd(bad ? mfb_pkg::MFB_REG_RX_BAD : mfb_pkg::MFB_REG_RX_FRM);
    chk("rx0 count", rd_v[0], 1);
    chk("rx1 count", rd_v[1], 0);
  endtask

  task automatic t_sfd();
    wr(mfb_pkg::MFB_REG_CTRL, 32'h1);
    rd(mfb_pkg::MFB_REG_CTRL);
    chk("strict on", rd_v[0], 1);
    clr();
    send_rx(5, 1'b0, 8'hd4);
    chk("rx0 dropped", rx_ok[0], 0);
    chk("rx0 no data", rn[0], 0);
    chk("rx1 kept", rx_ok[1], 1);
    chk("rx1 all bytes", rn[1], 17);
    wr(mfb_pkg::MFB_REG_CTRL, 32'h0);
    clr();
    send_rx(5, 1'b0, 8'hd4);
    chk("rx0 relaxed", rx_ok[0], 1);
  endtask

  initial begin
    clr();
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_regs();
    t_tx();
    t_irq();
    t_rx(1'b0);
    t_rx(1'b1);
    t_sfd();
    close_out();
  end
endmodule
